// >>> inc/smc_pkg.sv
package smc_pkg;

   // ***********************************************
   // system address map
   // ***********************************************
   localparam int          BANKS          = 8;
   localparam int          ADDR_W         = 24;
   localparam int          DATA_W         = 32;
   localparam int          LANES          = 4;
   localparam int          BASE_HI        = 31;
   localparam int          BASE_LO        = 29;
   localparam logic [2:0]  BASE_PATTERN   = 3'h2;
   localparam int          BANK_HI        = 28;
   localparam int          BANK_LO        = 26;

   // ***********************************************
   // per-bank settings
   // ***********************************************
   localparam logic [1:0]  WIDTH_8        = 2'h0;
   localparam logic [1:0]  WIDTH_16       = 2'h1;
   localparam logic [1:0]  WIDTH_32       = 2'h2;
   localparam int          WAIT_W         = 5;
   localparam int          IDLE_W         = 4;
   localparam logic [3:0]  LANES_8        = 4'h1;
   localparam logic [3:0]  LANES_16       = 4'h3;
   localparam logic [3:0]  LANES_32       = 4'hf;

   // ***********************************************
   // sequencer states
   // ***********************************************
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_TURN = 5'h02,
      ST_RD   = 5'h04,
      ST_WR   = 5'h08,
      ST_DONE = 5'h10
   } smc_state_type;

endpackage : smc_pkg

// >>> core/smc_decode.sv
`timescale 1ns/100ps
module smc_decode
   import smc_pkg::*;
(
   // system address
   input  wire logic [31:0]       addr_i,
   // decode result
   output logic                   hit_o,
   output logic [2:0]             bank_o,
   output logic [ADDR_W-1:0]      local_o
);

   // bits 25:24 ignored so that region mirrors the bank
   always_comb
   begin
      hit_o   = (addr_i[BASE_HI:BASE_LO] == BASE_PATTERN);
      bank_o  = addr_i[BANK_HI:BANK_LO];
      local_o = addr_i[ADDR_W-1:0];
   end

endmodule : smc_decode

// >>> core/smc_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - eight independent banks, 16 MB each
// - bank width 8, 16 or 32 bits
// - one chip select per bank, only addressed
// - chip select polarity programmable per bank
// - external only when address 31:29 is 010
// - address 28:26 picks bank directly
// - address 25:24 ignored, mirrors bank
// - address 23:0 drives external address bus
// - turnaround idle one to sixteen cycles
// - read then write same bank inserts idle
// - read and write waits per bank, to 32
// - burst rom first and later beat waits
// - page reads change only low address bits
// - per-bank byte lanes on reads control
// - four byte lane selects mark used bytes
// - write enable low only in writes
// - output enable low only in reads
// - single clock, counts in its periods
module smc_ctrl
   import smc_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      nrst_i,
   // access request
   input  wire logic                      req_i,
   input  wire logic                      we_i,
   input  wire logic [31:0]               addr_i,
   input  wire logic [DATA_W-1:0]         wdata_i,
   input  wire logic [LANES-1:0]          be_i,
   input  wire logic                      burst_i,
   output logic                           ready_o,
   output logic                           done_o,
   output logic                           err_o,
   output logic [DATA_W-1:0]              rdata_o,
   // per-bank configuration
   input  wire logic [BANKS*2-1:0]        cfg_width_i,
   input  wire logic [BANKS-1:0]          cfg_cs_high_i,
   input  wire logic [BANKS*IDLE_W-1:0]   cfg_idle_i,
   input  wire logic [BANKS*WAIT_W-1:0]   cfg_rd_wait_i,
   input  wire logic [BANKS*WAIT_W-1:0]   cfg_wr_wait_i,
   input  wire logic [BANKS*WAIT_W-1:0]   cfg_burst_wait_i,
   input  wire logic [BANKS-1:0]          cfg_burst_rom_i,
   input  wire logic [BANKS-1:0]          cfg_wprot_i,
   input  wire logic [BANKS-1:0]          cfg_rd_lanes_i,
   // external bus
   output logic [BANKS-1:0]               bank_select_out_o,
   output logic [LANES-1:0]               byte_lane_select_n_o,
   output logic                           we_n_o,
   output logic                           oe_n_o,
   output logic [ADDR_W-1:0]              ext_addr_o,
   output logic [DATA_W-1:0]              data_o,
   output logic                           data_oe_o,
   input  wire logic [DATA_W-1:0]         data_i,
   // status
   output logic                           busy_o
);

   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed
   {
      smc_state_type       st;
      logic [2:0]          bank;
      logic                we;
      logic                burst;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [LANES-1:0]    lanes;
      logic [WAIT_W-1:0]   cnt;
      logic                beat1;
      logic                last_rd;
      logic [2:0]          last_bank;
      logic [BANKS-1:0]    cs_act;
      logic [LANES-1:0]    bls_n;
      logic                we_n;
      logic                oe_n;
      logic                doe;
      logic [DATA_W-1:0]   rdata;
      logic                done;
      logic                err;
   } smc_regs_type;

   smc_regs_type r_q;
   smc_regs_type r_d;

   logic               hit;
   logic [2:0]         dbank;
   logic [ADDR_W-1:0]  dlocal;

   smc_decode u_decode
   (
      .addr_i  (addr_i),
      .hit_o   (hit),
      .bank_o  (dbank),
      .local_o (dlocal)
   );

   // ***********************************************
   // per-bank fields
   // ***********************************************
   logic [1:0]         width_b  [BANKS];
   logic [IDLE_W-1:0]  idle_b   [BANKS];
   logic [WAIT_W-1:0]  rdw_b    [BANKS];
   logic [WAIT_W-1:0]  wrw_b    [BANKS];
   logic [WAIT_W-1:0]  bw_b     [BANKS];

   genvar gi;
   generate
      for (gi = 0; gi < BANKS; gi++)
      begin : g_bank
         assign width_b[gi] = cfg_width_i[gi*2 +: 2];
         assign idle_b[gi]  = cfg_idle_i[gi*IDLE_W +: IDLE_W];
         assign rdw_b[gi]   = cfg_rd_wait_i[gi*WAIT_W +: WAIT_W];
         assign wrw_b[gi]   = cfg_wr_wait_i[gi*WAIT_W +: WAIT_W];
         assign bw_b[gi]    = cfg_burst_wait_i[gi*WAIT_W +: WAIT_W];
         // polarity applied on the registered active flag
         assign bank_select_out_o[gi] = r_q.cs_act[gi] ~^ cfg_cs_high_i[gi];
      end
   endgenerate

   // ***********************************************
   // sequencer
   // ***********************************************
   logic [LANES-1:0] lane_mask;
   logic             turn_needed;

   always_comb
   begin
      r_d       = r_q;
      r_d.done  = 1'b0;
      r_d.err   = 1'b0;
      lane_mask = LANES_32;
      // narrow banks use only the low lanes of the bus
      unique case (width_b[dbank])
         WIDTH_8:  lane_mask = LANES_8;
         WIDTH_16: lane_mask = LANES_16;
         default:  lane_mask = LANES_32;
      endcase
      turn_needed = r_q.last_rd && we_i && (r_q.last_bank == dbank);

      unique case (r_q.st)
         ST_IDLE:
         begin
            if (req_i)
            begin
               if (!hit)
               begin
                  r_d.err  = 1'b1;
                  r_d.done = 1'b1;
               end
               else
               begin
                  r_d.bank  = dbank;
                  r_d.we    = we_i;
                  r_d.burst = burst_i && !we_i && cfg_burst_rom_i[dbank];
                  r_d.addr  = dlocal;
                  r_d.wdata = wdata_i;
                  r_d.lanes = be_i & lane_mask;
                  r_d.beat1 = 1'b1;
                  if (turn_needed)
                  begin
                     // idle field value n gives n+1 cycles
                     r_d.cnt = {1'b0, idle_b[dbank]};
                     r_d.st  = ST_TURN;
                  end
                  else
                  begin
                     r_d.cs_act[dbank] = 1'b1;
                     if (we_i)
                     begin
                        r_d.cnt = wrw_b[dbank];
                        r_d.st  = ST_WR;
                        r_d.doe = 1'b1;
                        if (!cfg_wprot_i[dbank])
                        begin
                           r_d.we_n  = 1'b0;
                           r_d.bls_n = ~(be_i & lane_mask);
                        end
                     end
                     else
                     begin
                        r_d.cnt  = rdw_b[dbank];
                        r_d.st   = ST_RD;
                        r_d.oe_n = 1'b0;
                        if (cfg_rd_lanes_i[dbank])
                        begin
                           r_d.bls_n = ~(be_i & lane_mask);
                        end
                     end
                  end
               end
            end
         end
         ST_TURN:
         begin
            // idle cycles count in controller clock periods
            if (r_q.cnt == '0)
            begin
               r_d.last_rd          = 1'b0;
               r_d.cs_act[r_q.bank] = 1'b1;
               r_d.cnt              = wrw_b[r_q.bank];
               r_d.st               = ST_WR;
               r_d.doe              = 1'b1;
               if (!cfg_wprot_i[r_q.bank])
               begin
                  r_d.we_n  = 1'b0;
                  r_d.bls_n = ~r_q.lanes;
               end
            end
            else
            begin
               r_d.cnt = r_q.cnt - 1'b1;
            end
         end
         ST_RD:
         begin
            if (r_q.cnt == '0)
            begin
               r_d.rdata = data_i;
               r_d.done  = 1'b1;
               if (r_q.burst && req_i && !we_i && hit && (dbank == r_q.bank)
                   && (dlocal[ADDR_W-1:LANES] == r_q.addr[ADDR_W-1:LANES]))
               begin
                  // page beat: only low address bits move, strobes stay
                  r_d.addr  = dlocal;
                  r_d.cnt   = bw_b[r_q.bank];
                  r_d.beat1 = 1'b0;
               end
               else
               begin
                  r_d.st        = ST_DONE;
                  r_d.cs_act    = '0;
                  r_d.oe_n      = 1'b1;
                  r_d.bls_n     = '1;
                  r_d.last_rd   = 1'b1;
                  r_d.last_bank = r_q.bank;
               end
            end
            else
            begin
               r_d.cnt = r_q.cnt - 1'b1;
            end
         end
         ST_WR:
         begin
            if (r_q.cnt == '0)
            begin
               r_d.st        = ST_DONE;
               r_d.done      = 1'b1;
               r_d.cs_act    = '0;
               r_d.we_n      = 1'b1;
               r_d.bls_n     = '1;
               r_d.doe       = 1'b0;
               r_d.last_rd   = 1'b0;
               r_d.last_bank = r_q.bank;
            end
            else
            begin
               r_d.cnt = r_q.cnt - 1'b1;
            end
         end
         ST_DONE:
         begin
            r_d.st = ST_IDLE;
         end
         default:
         begin
            r_d.st     = ST_IDLE;
            r_d.cs_act = '0;
            r_d.we_n   = 1'b1;
            r_d.oe_n   = 1'b1;
            r_d.bls_n  = '1;
            r_d.doe    = 1'b0;
         end
      endcase
   end

   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         r_q           <= '0;
         r_q.st        <= ST_IDLE;
         r_q.bls_n     <= '1;
         r_q.we_n      <= 1'b1;
         r_q.oe_n      <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   assign ready_o              = (r_q.st == ST_IDLE);
   assign done_o               = r_q.done;
   assign err_o                = r_q.err;
   assign rdata_o              = r_q.rdata;
   assign byte_lane_select_n_o = r_q.bls_n;
   assign we_n_o               = r_q.we_n;
   assign oe_n_o               = r_q.oe_n;
   assign ext_addr_o           = r_q.addr;
   assign data_o               = r_q.wdata;
   assign data_oe_o            = r_q.doe;
   assign busy_o               = (r_q.st != ST_IDLE);

endmodule : smc_ctrl

// >>> bench/smc_mem_model.sv
`timescale 1ns/100ps
module smc_mem_model
#(
   parameter int DLY = 0
)
(
   // strobes from the controller
   input  wire logic        sel_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [3:0]  bls_n_i,
   input  wire logic [23:0] addr_i,
   // data bus
   input  wire logic [31:0] data_i,
   output logic      [31:0] data_o
);
   logic [31:0] mem [0:255];
   logic [31:0] last = 32'h0;
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = {4{8'(i)}} ^ 32'ha5c3e10f;
   end
   // released bus shows the inverse of the last driven word
   always @*
      if (sel_i && !oe_n_i)
         last = mem[addr_i[7:0]];
   assign #(DLY) data_o = (sel_i && !oe_n_i) ? mem[addr_i[7:0]] : ~last;
   always @*
      if (sel_i && !we_n_i)
         for (int i = 0; i < 4; i++)
            if (!bls_n_i[i])
               mem[addr_i[7:0]][8*i+:8] = data_i[8*i+:8];
endmodule : smc_mem_model

// >>> bench/smc_ctrl_checker.sv
`timescale 1ns/100ps
module smc_ctrl_checker
   import smc_pkg::*;
(
   // request side
   input wire logic              clk_i,
   input wire logic              nrst_i,
   input wire logic              req_i,
   input wire logic              we_i,
   input wire logic [31:0]       addr_i,
   input wire logic              ready_o,
   input wire logic              done_o,
   input wire logic              err_o,
   // bank settings
   input wire logic [BANKS-1:0]  cfg_cs_high_i,
   input wire logic [BANKS-1:0]  cfg_wprot_i,
   input wire logic [BANKS-1:0]  cfg_rd_lanes_i,
   // external bus
   input wire logic [BANKS-1:0]  bank_select_out_o,
   input wire logic [LANES-1:0]  byte_lane_select_n_o,
   input wire logic              we_n_o,
   input wire logic              oe_n_o,
   input wire logic [ADDR_W-1:0] ext_addr_o,
   input wire logic              data_oe_o
);
   wire logic [BANKS-1:0] act = ~(bank_select_out_o ^ cfg_cs_high_i);
   wire logic             take = ready_o && req_i;
   wire logic             ext = addr_i[BASE_HI:BASE_LO] == BASE_PATTERN;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   property p_cs; $onehot0(act); endproperty
   a_cs: assert property (p_cs) else $error("two selects");
   property p_bank; take && ext && !we_i |=> act == 8'h1 << $past(addr_i[28:26]); endproperty
   a_bank: assert property (p_bank) else $error("bad select");
   property p_addr; take && ext && !we_i |=> ext_addr_o == $past(addr_i[23:0]); endproperty
   a_addr: assert property (p_addr) else $error("bad address");
   property p_err; take && !ext |=> done_o && err_o && act == '0 && we_n_o && oe_n_o; endproperty
   a_err: assert property (p_err) else $error("bad error cycle");
   property p_we; !we_n_o |-> data_oe_o && act != '0; endproperty
   a_we: assert property (p_we) else $error("stray write");
   property p_oe; !oe_n_o |-> we_n_o && !data_oe_o && act != '0; endproperty
   a_oe: assert property (p_oe) else $error("stray read");
   property p_rl; !oe_n_o && (act & cfg_rd_lanes_i) == '0 |-> byte_lane_select_n_o == '1; endproperty
   a_rl: assert property (p_rl) else $error("read lanes");
   property p_wp; data_oe_o && (act & cfg_wprot_i) != '0 |-> we_n_o && &byte_lane_select_n_o;
   endproperty
   a_wp: assert property (p_wp) else $error("protected write");
   property p_rst; disable iff (1'b0) !nrst_i |=> we_n_o && oe_n_o && act == '0; endproperty
   a_rst: assert property (p_rst) else $error("strobe in reset");
   c_rd: cover property (take && ext && !we_i);
   c_wr: cover property (take && ext && we_i);
   c_err: cover property (done_o && err_o);
   c_page: cover property (done_o && !oe_n_o);
endmodule : smc_ctrl_checker

// >>> bench/tb_smc_ctrl.sv
`timescale 1ns/100ps
module tb_smc_ctrl;
   import smc_pkg::*;
   logic                    clk_i = 1'b0;
   logic                    nrst_i = 1'b0;
   logic                    req_i = 1'b0;
   logic                    we_i = 1'b0;
   logic                    burst_i = 1'b0;
   logic [31:0]             addr_i = 32'h0;
   logic [31:0]             wdata_i = 32'h0;
   logic [3:0]              be_i = 4'hf;
   logic [15:0]             cfg_width_i;
   logic [7:0]              cfg_cs_high_i = 8'ha5;
   logic [7:0]              cfg_burst_rom_i = 8'h04;
   logic [7:0]              cfg_wprot_i = 8'h40;
   logic [7:0]              cfg_rd_lanes_i = 8'h0f;
   logic [31:0]             cfg_idle_i;
   logic [39:0]             cfg_rd_wait_i, cfg_wr_wait_i;
   logic [39:0]             cfg_burst_wait_i;
   logic                    ready_o, done_o, err_o, we_n_o, oe_n_o, data_oe_o, busy_o;
   logic [31:0]             rdata_o, data_o, md, rd, cs, ea, er, bz;
   wire logic [31:0]        data_i = data_oe_o ? data_o : md;
   logic [7:0]              bank_select_out_o;
   logic [3:0]              byte_lane_select_n_o, bl;
   logic [23:0]             ext_addr_o;
   int                      fails = 0;
   int                      compares = 0;
   int                      cycles = 0;
   smc_ctrl uut
   (
      .clk_i, .nrst_i, .req_i, .we_i, .addr_i, .wdata_i, .be_i, .burst_i, .ready_o,
      .done_o, .err_o, .rdata_o, .cfg_width_i, .cfg_cs_high_i, .cfg_idle_i,
      .cfg_rd_wait_i, .cfg_wr_wait_i, .cfg_burst_wait_i, .cfg_burst_rom_i, .cfg_wprot_i,
      .cfg_rd_lanes_i, .bank_select_out_o, .byte_lane_select_n_o, .we_n_o, .oe_n_o,
      .ext_addr_o, .data_o, .data_oe_o, .data_i, .busy_o
   );
   smc_mem_model #(.DLY(3)) mem
   (
      .sel_i(|(~(bank_select_out_o ^ cfg_cs_high_i))), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
      .bls_n_i(byte_lane_select_n_o), .addr_i(ext_addr_o), .data_i(data_o), .data_o(md)
   );
   always #5 clk_i = ~clk_i;
   // ************
   // bench tasks
   // ************
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick
   task automatic chk(input string s, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   function automatic logic [31:0] mk(input logic [3:0] l);
      return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
   endfunction : mk
   task automatic acc(input logic w, input logic [31:0] a, d, output int n);
      // the take edge counts as the first cycle
      n = 1;
      {bl, cs, ea} = 'x;
      // let an edge pass so req_i never falls and rises in one step
      tick();
      while (ready_o !== 1'b1)
         tick();
      req_i = 1'b1;
      we_i = w;
      addr_i = a;
      wdata_i = d;
      tick();
      req_i = 1'b0;
      bz = 32'(busy_o);
      while (done_o !== 1'b1 && n < 99)
      begin
         if (!(we_n_o && oe_n_o) || data_oe_o)
            {bl, cs, ea} = {byte_lane_select_n_o, 32'(bank_select_out_o), 32'(ext_addr_o)};
         tick();
         n++;
      end
      if (done_o !== 1'b1)
         fails++;
      rd = rdata_o;
      er = 32'(err_o);
   endtask : acc
   task automatic t_rw();
      logic [31:0] a, d, o;
      logic [3:0]  l;
      int          n;
      for (int b = 0; b < 8; b++)
      begin
         a = {3'h2, 3'(b), 2'(b), 24'h5a0010 + 24'(b)};
         d = 32'h13579bdf ^ {4{8'(b)}};
         l = (b % 3 == 0) ? LANES_8 : (b % 3 == 1) ? LANES_16 : LANES_32;
         be_i = b[0] ? 4'hd : 4'hf;
         acc(1'b0, a, 32'h0, n);
         o = rd;
         chk("busy flag", 32'h1, bz);
         acc(1'b1, a, d, n);
         chk("write cycles", cfg_wr_wait_i[5*b+:5] + cfg_idle_i[4*b+:4] + 32'h3,
             n);
         chk("write lanes", cfg_wprot_i[b] ? 32'hf : {28'h0, ~(l & be_i)},
             {28'h0, bl});
         acc(1'b0, a, 32'h0, n);
         chk("read cycles", cfg_rd_wait_i[5*b+:5] + 32'h2, n);
         d = cfg_wprot_i[b] ? o : (o & ~mk(l & be_i)) | (d & mk(l & be_i));
         chk("read data", d & mk(l), rd & mk(l));
         chk("read lanes", cfg_rd_lanes_i[b] ? {28'h0, ~(l & be_i)} : 32'hf,
             {28'h0, bl});
         chk("selects", {24'h0, ~((8'h1 << b) ^ cfg_cs_high_i)}, cs);
         chk("address", {8'h0, a[23:0]}, ea);
         chk("error flag", 32'h0, er);
      end
      $display("test read write done");
   endtask : t_rw
   task automatic t_err();
      int n;
      for (int i = 0; i < 2; i++)
      begin
         acc(i[0], i[0] ? 32'h0000_0010 : 32'h6000_0010, 32'h0, n);
         chk("error cycles", 32'h1, n);
         chk("error flag", 32'h1, er);
         chk("error busy", 32'h0, bz);
      end
      acc(1'b0, 32'h4400_0020, 32'h0, n);
      acc(1'b1, 32'h4800_0020, 32'h0, n);
      chk("cross bank write", cfg_wr_wait_i[14:10] + 32'h2, n);
      $display("test error and cross bank done");
   endtask : t_err
   task automatic t_burst();
      int n;
      be_i = 4'hf;
      acc(1'b1, 32'h4800_0040, 32'h1234_5678, n);
      acc(1'b1, 32'h4800_0041, 32'h9abc_def0, n);
      tick();
      while (ready_o !== 1'b1)
         tick();
      n = 1;
      req_i = 1'b1;
      we_i = 1'b0;
      burst_i = 1'b1;
      addr_i = 32'h4800_0040;
      tick();
      // next word of the same page stands before the last wait cycle
      addr_i = 32'h4800_0041;
      while (done_o !== 1'b1 && n < 99)
      begin
         tick();
         n++;
      end
      chk("first beat cycles", cfg_rd_wait_i[14:10] + 32'h2, n);
      chk("first beat data", 32'h1234_5678, rdata_o);
      chk("page strobe", 32'h0, 32'(oe_n_o));
      chk("page address", 32'h0000_0041, 32'(ext_addr_o));
      req_i = 1'b0;
      burst_i = 1'b0;
      n = 0;
      do
      begin
         tick();
         n++;
      end
      while (done_o !== 1'b1 && n < 99);
      if (done_o !== 1'b1)
         fails++;
      chk("next beat cycles", cfg_burst_wait_i[14:10] + 32'h1, n);
      chk("next beat data", 32'h9abc_def0, rdata_o);
      $display("test page read done");
   endtask : t_burst
   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         stop_test();
      end
   end
   initial
   begin
      for (int b = 0; b < 8; b++)
      begin
         cfg_width_i[2*b+:2] = 2'(b % 3);
         cfg_idle_i[4*b+:4] = (b == 7) ? 4'hf : 4'(b);
         cfg_rd_wait_i[5*b+:5] = (b == 7) ? 5'h1f : 5'(b);
         cfg_wr_wait_i[5*b+:5] = 5'(2 * b);
         cfg_burst_wait_i[5*b+:5] = 5'(b + 1);
      end
      repeat (16) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      chk("idle selects", {24'h0, ~cfg_cs_high_i}, 32'(bank_select_out_o));
      chk("idle strobes", 32'h3, {30'h0, we_n_o, oe_n_o});
      $display("test reset done");
      t_rw();
      t_err();
      t_burst();
      stop_test();
   end
endmodule : tb_smc_ctrl
bind smc_ctrl smc_ctrl_checker u_chk
(
   .clk_i, .nrst_i, .req_i, .we_i, .addr_i, .ready_o, .done_o, .err_o, .cfg_cs_high_i,
   .cfg_wprot_i, .cfg_rd_lanes_i, .bank_select_out_o, .byte_lane_select_n_o, .we_n_o,
   .oe_n_o, .ext_addr_o, .data_oe_o
);
